// file: rtl/tcv_pkg.sv
// Package: register map, field positions and widths of the compare values
package tcv_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] TCV_OFF_MCH2   = 8'h5c;
   localparam logic [7:0] TCV_OFF_MCH3   = 8'h60;
   localparam logic [7:0] TCV_OFF_CH0X   = 8'h64;
   localparam logic [7:0] TCV_OFF_CH1X   = 8'h68;
   localparam logic [7:0] TCV_OFF_CH2X   = 8'h6c;
   localparam logic [7:0] TCV_OFF_CTL    = 8'h74;
   localparam logic [7:0] TCV_OFF_CFG    = 8'h78;
   // ==========================================================
   // Value registers: index 0,1 multi mode 2,3; index 2..4 extra ch0..2
   localparam int         TCV_NUM_VAL    = 5;
   localparam int         TCV_NUM_MULTI  = 2;
   localparam int         TCV_NUM_EXTRA  = 3;
   localparam int         TCV_VAL_W      = 16;
   localparam logic [15:0] TCV_VAL_RST   = 16'h0000;
   localparam logic [31:0] TCV_REG_RST   = 32'h0000_0000;
   // ==========================================================
   // Control: composite PWM enables, ch3..ch0 at bits 31..28
   localparam int         TCV_CPWM_LSB   = 28;
   localparam int         TCV_CPWM_W     = 4;
   // Config: input-mode bits of multi ch2/3, shadow enables per value reg
   localparam int         TCV_INMODE_LSB = 0;
   localparam int         TCV_SHADOW_LSB = 8;
   // ==========================================================
   // Decoded register select
   typedef enum logic [2:0] {
      TCV_SEL_MCH2, TCV_SEL_MCH3, TCV_SEL_CH0X, TCV_SEL_CH1X,
      TCV_SEL_CH2X, TCV_SEL_CTL, TCV_SEL_CFG, TCV_SEL_NONE
   } tcv_sel_e;
   // AXI responses and full-word strobe
   localparam logic [1:0] TCV_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TCV_RESP_SLVERR = 2'h2;
   localparam logic [3:0] TCV_STRB_WORD   = 4'hf;
endpackage

// file: rtl/tcv_top.sv
// Timer channel capture/compare value registers with AXI4-Lite slave
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Input-mode multi ch2/3 value holds counter at last capture, read only.
// [RULE2] Output-mode multi channel value is compare threshold against counter.
// [RULE3] With shadow on, active compare reloads from written value on update.
// [RULE4] Software uses full 32-bit word accesses only on these registers.
// [RULE5] Output channels 0..2 extra field gives second 16-bit counter compare.
// [RULE6] Extra compare acts only while that channel's composite PWM bit is 1.
// [RULE7] Software keeps bits 31:16 at reset value when writing.
// [RULE8] All value and extra compare registers reset to zero.
// [RULE9] Composite PWM enables sit at control bits 31..28 for ch3..ch0.
// [RULE10] Writes to an input-mode multi channel value are ignored.

// ==========================================================
// Register map
//   0x5c  multi ch2 value, low 16 bits stored, upper half reads 0
//   0x60  multi ch3 value, low 16 bits stored, upper half reads 0
//   0x64  ch0 extra compare value
//   0x68  ch1 extra compare value
//   0x6c  ch2 extra compare value
//   0x74  control: composite PWM enables ch3..ch0 at bits 31..28
//   0x78  config: bit0/bit1 input mode of multi ch2/ch3,
//         bits 8..12 shadow enables of the five value registers
//   Any other low byte is a hole: reads 0, both directions SLVERR.
//   Only the low address byte is decoded, so the map repeats above.
//
// ==========================================================
// Bus timing
//   After reset release the three ready flags rise on the first edge,
//   so the earliest request is taken on the second edge.
//   Write: AW and W are held in separate one-entry slots and may arrive
//   in either order. The write commits on the edge after the later of
//   the two is taken, provided no response is still waiting. At that
//   edge the register changes, bvalid rises and both readies return.
//   bvalid and bresp then stand until an edge with bready high.
//   Read: the address is decoded straight from the bus, so it must be
//   held until arready is seen high. rvalid rises one edge later and
//   stands with rdata and rresp until an edge with rready high; arready
//   comes back on that same edge.
//   Partial strobes are refused with SLVERR and change nothing, which
//   keeps a half-written compare value from ever reaching the counter
//   comparison.
//
// ==========================================================
// Timer side timing
//   A capture pulse in input mode loads the stored value on its edge.
//   Without shadowing the active copy follows the stored value one
//   edge later; with shadowing it follows only on an edge that sees
//   the update pulse, so software can rewrite the preload freely in
//   mid-period without a glitch on the output compare.
//   Match outputs are registered: a match shows one edge after the
//   counter and the active copy were equal. The timer core must allow
//   for that one-cycle lag when it turns matches into waveforms.
//   Extra matches are forced low while the channel's composite PWM
//   enable is clear; the active extra copy still tracks its preload so
//   that turning the mode on needs no reload.
//
// ==========================================================
// Limitations
//   Software reads always return the stored value, never the active
//   copy, so a shadowed value read back may not be the one in use.
//   In input mode every software write to that value is dropped, even
//   in the same cycle as no capture; this avoids any write/capture
//   race at the cost of not being able to preset a captured value.
//   The channel 3 composite PWM bit is stored and read back only; its
//   extra compare register lives outside this block.
//   Capture pulses are taken as synchronous, single-cycle events; edge
//   detection and prescaling happen in the channel input stage.
module tcv_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [ADDR_W-1:0]             s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [tcv_pkg::TCV_VAL_W-1:0] counter,
   input  wire logic                          update_event,
   input  wire logic                          capture_mch2,
   input  wire logic                          capture_mch3,
   output logic [tcv_pkg::TCV_VAL_W-1:0]      active_compare [5],
   output logic [1:0]                         multi_match,
   output logic [2:0]                         extra_enable,
   output logic [2:0]                         extra_match
);
   import tcv_pkg::*;

   initial begin
      if (ADDR_W < 8 || ADDR_W > 32)
         $error("ADDR_W must be 8 to 32");
   end

   // ==========================================================
   // Storage
   logic [TCV_VAL_W-1:0]         value_q [TCV_NUM_VAL];
   logic [TCV_CPWM_W-1:0]        cpwm_en;
   logic [TCV_NUM_MULTI-1:0]     input_mode;
   logic [TCV_NUM_VAL-1:0]       shadow_en;
   logic                         aw_full;
   logic                         w_full;
   logic [ADDR_W-1:0]            aw_addr;
   logic [31:0]                  w_data;
   logic [3:0]                   w_strb;
   logic                         do_write;
   tcv_sel_e                     wr_sel;
   tcv_sel_e                     rd_sel;
   logic                         wr_word;
   logic [TCV_NUM_MULTI-1:0]     capture;

   assign capture = {capture_mch3, capture_mch2};

   // Address decode, low byte only; aliases repeat above it
   function automatic tcv_sel_e decode(input logic [7:0] a);
      tcv_sel_e s;
      case (a)
         TCV_OFF_MCH2: s = TCV_SEL_MCH2;
         TCV_OFF_MCH3: s = TCV_SEL_MCH3;
         TCV_OFF_CH0X: s = TCV_SEL_CH0X;
         TCV_OFF_CH1X: s = TCV_SEL_CH1X;
         TCV_OFF_CH2X: s = TCV_SEL_CH2X;
         TCV_OFF_CTL:  s = TCV_SEL_CTL;
         TCV_OFF_CFG:  s = TCV_SEL_CFG;
         default:      s = TCV_SEL_NONE;
      endcase
      return s;
   endfunction

   assign wr_sel   = decode(aw_addr[7:0]);
   assign rd_sel   = decode(s_axi_araddr[7:0]);
   assign wr_word  = (w_strb == TCV_STRB_WORD); // [RULE4]
   // Write commits once address and data are both held and B is free
   assign do_write = aw_full && w_full && !s_axi_bvalid;

   // ==========================================================
   // Write address channel: one address held at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full       <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr       <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full       <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_addr       <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full       <= 1'b0;
         s_axi_awready <= 1'b1;
      end else begin
         s_axi_awready <= !aw_full;
      end
   end

   // Write data channel, independent of the address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full       <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data       <= TCV_REG_RST;
         w_strb       <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full       <= 1'b1;
         s_axi_wready <= 1'b0;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
      end else if (do_write) begin
         w_full       <= 1'b0;
         s_axi_wready <= 1'b1;
      end else begin
         s_axi_wready <= !w_full;
      end
   end

   // Write response; partial strobes and holes answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= TCV_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_word && wr_sel != TCV_SEL_NONE) ?
                         TCV_RESP_OKAY : TCV_RESP_SLVERR; // [RULE4]
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Control and config; unused bits written are simply dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpwm_en    <= '0;
         input_mode <= '0;
         shadow_en  <= '0;
      end else if (do_write && wr_word) begin
         if (wr_sel == TCV_SEL_CTL)
            cpwm_en <= w_data[TCV_CPWM_LSB +: TCV_CPWM_W]; // [RULE9]
         if (wr_sel == TCV_SEL_CFG) begin
            input_mode <= w_data[TCV_INMODE_LSB +: TCV_NUM_MULTI];
            shadow_en  <= w_data[TCV_SHADOW_LSB +: TCV_NUM_VAL];
         end
      end
   end

   // ==========================================================
   // Value storage: capture in input mode, software write otherwise.
   // Only the low half is kept, so bits 31:16 cannot leak back. [RULE7]
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < TCV_NUM_VAL; i++) begin
            value_q[i] <= TCV_VAL_RST; // [RULE8]
         end
      end else begin
         for (int i = 0; i < TCV_NUM_VAL; i++) begin
            if (i < TCV_NUM_MULTI && input_mode[i]) begin
               // Software writes cannot disturb a capture [RULE10]
               if (capture[i])
                  value_q[i] <= counter; // [RULE1]
            end else if (do_write && wr_word && int'(wr_sel) == i) begin
               value_q[i] <= w_data[TCV_VAL_W-1:0];
            end
         end
      end
   end

   // Active compare: direct copy, or reload only on update when shadowed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < TCV_NUM_VAL; i++) begin
            active_compare[i] <= TCV_VAL_RST; // [RULE8]
         end
      end else begin
         for (int i = 0; i < TCV_NUM_VAL; i++) begin
            if (!shadow_en[i] || update_event)
               active_compare[i] <= value_q[i]; // [RULE3]
         end
      end
   end

   // ==========================================================
   // Compare outputs, registered so a match lags the counter one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         multi_match  <= '0;
         extra_enable <= '0;
         extra_match  <= '0;
      end else begin
         for (int i = 0; i < TCV_NUM_MULTI; i++) begin
            multi_match[i] <= !input_mode[i] &&
                              counter == active_compare[i]; // [RULE2]
         end
         for (int i = 0; i < TCV_NUM_EXTRA; i++) begin
            extra_enable[i] <= cpwm_en[i]; // [RULE6]
            // Extra compare ignored unless composite PWM is on
            extra_match[i]  <= cpwm_en[i] &&
               counter == active_compare[TCV_NUM_MULTI+i]; // [RULE5] [RULE6]
         end
      end
   end

   // ==========================================================
   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= TCV_REG_RST;
         s_axi_rresp   <= TCV_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= TCV_RESP_OKAY;
         s_axi_rdata   <= TCV_REG_RST;
         case (rd_sel)
            TCV_SEL_MCH2, TCV_SEL_MCH3, TCV_SEL_CH0X,
            TCV_SEL_CH1X, TCV_SEL_CH2X: begin
               s_axi_rdata[TCV_VAL_W-1:0] <= value_q[int'(rd_sel)];
            end
            TCV_SEL_CTL: begin
               s_axi_rdata[TCV_CPWM_LSB +: TCV_CPWM_W] <= cpwm_en;
            end
            TCV_SEL_CFG: begin
               s_axi_rdata[TCV_INMODE_LSB +: TCV_NUM_MULTI] <= input_mode;
               s_axi_rdata[TCV_SHADOW_LSB +: TCV_NUM_VAL]   <= shadow_en;
            end
            default: begin
               s_axi_rresp <= TCV_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_arready <= !s_axi_rvalid;
      end
   end
endmodule

// file: testbench/tcv_assertions.sv
// Checker: output timing relations of the compare value block
`timescale 1ns/1ps
module tcv_checker
   import tcv_pkg::*;
(
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic                 s_axi_bvalid,
   input wire logic [TCV_VAL_W-1:0] counter,
   input wire logic                 update_event,
   input wire logic                 capture_mch2,
   input wire logic                 capture_mch3,
   input wire logic [TCV_VAL_W-1:0] active_compare [5],
   input wire logic [1:0]           multi_match,
   input wire logic [2:0]           extra_enable,
   input wire logic [2:0]           extra_match
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rel_s;
      $rose(aresetn);
   endsequence
   rst_zero_a: assert property (
      rel_s |-> {active_compare[0], active_compare[1], active_compare[2],
                 active_compare[3], active_compare[4]} == '0)
      else $error("compare not zero after reset");
   multi_eq_a: assert property (
      multi_match[1] |-> $past(counter) == $past(active_compare[1]))
      else $error("multi match without equal value");
   extra_eq_a: assert property (
      extra_match[0] |-> $past(counter) == $past(active_compare[2]))
      else $error("extra match without equal value");
   match_gated_a: assert property (
      extra_match != 3'h0 |-> (extra_match & ~extra_enable) == 3'h0)
      else $error("extra match while mode off");
   enable_write_a: assert property (
      $changed(extra_enable) |-> $past(s_axi_bvalid))
      else $error("enable moved without a write");
   shadow_load_a: assert property (
      $changed(active_compare[1]) |-> $past(s_axi_bvalid)
         || $past(update_event) || $past(capture_mch3, 2))
      else $error("active ch3 value moved without cause");
   capture_load_a: assert property (
      $changed(active_compare[0]) |-> $past(s_axi_bvalid)
         || $past(update_event) || $past(capture_mch2, 2))
      else $error("active ch2 value moved without cause");
   extra_load_a: assert property (
      $changed(active_compare[2]) |-> $past(s_axi_bvalid)
         || $past(update_event))
      else $error("active extra value moved without cause");
endmodule
bind tcv_top tcv_checker chk_u (.aclk, .aresetn, .s_axi_bvalid, .counter,
   .update_event, .capture_mch2, .capture_mch3, .active_compare,
   .multi_match, .extra_enable, .extra_match);

// file: testbench/testbench.sv
// Testbench: register access and compare behaviour of the value block
`timescale 1ns/1ps
module testbench;
   import tcv_pkg::*;
   // ==========================================================
   // Signals
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, update_event;
   logic        capture_mch2, capture_mch3;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, multi_match;
   logic [2:0]  extra_enable, extra_match;
   logic [15:0] counter;
   logic [15:0] active_compare [5];
   int          n_errors, cmp_count;
   tcv_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .counter, .update_event,
      .capture_mch2, .capture_mch3, .active_compare, .multi_match,
      .extra_enable, .extra_match);
   // 40 ns clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // ==========================================================
   // Shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Ready flags are read before this edge's updates land
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask
   task automatic print_verdict;
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      logic [7:0] offs [5] = '{TCV_OFF_MCH2, TCV_OFF_MCH3, TCV_OFF_CH0X,
                               TCV_OFF_CH1X, TCV_OFF_CH2X};
      foreach (offs[i]) rd(offs[i], TCV_REG_RST, TCV_RESP_OKAY);
      foreach (active_compare[i])
         chk("act", 32'h0, 32'(active_compare[i]));
      rd(8'h40, 32'h0, TCV_RESP_SLVERR);
   endtask
   task automatic t_extra;
      // Full word, upper half kept at zero
      wr(TCV_OFF_CH0X, 32'h0000_1234, TCV_STRB_WORD,
         TCV_RESP_OKAY);
      rd(TCV_OFF_CH0X, 32'h0000_1234, TCV_RESP_OKAY);
      counter <= 16'h1234;
      tick(2);
      chk("act2", 32'h1234, 32'(active_compare[2]));
      chk("xmatch", 32'h0, 32'(extra_match));
      wr(TCV_OFF_CTL, 32'h1000_0000, TCV_STRB_WORD, TCV_RESP_OKAY);
      tick(2);
      chk("xen", 32'h1, 32'(extra_enable));
      chk("xmatch", 32'h1, 32'(extra_match));
      wr(TCV_OFF_CTL, 32'hf000_0000, TCV_STRB_WORD, TCV_RESP_OKAY);
      rd(TCV_OFF_CTL, 32'hf000_0000, TCV_RESP_OKAY);
      chk("xen", 32'h7, 32'(extra_enable));
      chk("xmatch", 32'h1, 32'(extra_match));
      // Partial strobe must leave the value untouched
      wr(TCV_OFF_CH0X, 32'h9, 4'h3, TCV_RESP_SLVERR);
      rd(TCV_OFF_CH0X, 32'h1234, TCV_RESP_OKAY);
   endtask
   task automatic t_shadow;
      wr(TCV_OFF_CFG, 32'h0000_0200, TCV_STRB_WORD, TCV_RESP_OKAY);
      wr(TCV_OFF_MCH3, 32'h0000_0055, TCV_STRB_WORD, TCV_RESP_OKAY);
      tick(2);
      chk("act1", 32'h0, 32'(active_compare[1]));
      update_event <= 1'b1;
      tick(1);
      update_event <= 1'b0;
      tick(2);
      chk("act1", 32'h55, 32'(active_compare[1]));
      counter <= 16'h0055;
      tick(2);
      chk("mmatch", 32'h2, 32'(multi_match));
   endtask
   // Ch3 stays in output mode, so its capture pulse is ignored
   task automatic t_capture;
      wr(TCV_OFF_CFG, 32'h0000_0001, TCV_STRB_WORD, TCV_RESP_OKAY);
      counter <= 16'h7777;
      capture_mch2 <= 1'b1;
      capture_mch3 <= 1'b1;
      tick(1);
      capture_mch2 <= 1'b0;
      capture_mch3 <= 1'b0;
      rd(TCV_OFF_MCH2, 32'h7777, TCV_RESP_OKAY);
      rd(TCV_OFF_MCH3, 32'h0055, TCV_RESP_OKAY);
      wr(TCV_OFF_MCH2, 32'h1111, TCV_STRB_WORD, TCV_RESP_OKAY);
      rd(TCV_OFF_MCH2, 32'h7777, TCV_RESP_OKAY);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, update_event,
       capture_mch2, capture_mch3, s_axi_awaddr, s_axi_araddr, s_axi_wdata,
       s_axi_wstrb, counter} = '0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_extra;
      t_shadow;
      t_capture;
      print_verdict;
   end
   initial begin
      repeat (2000) @(posedge aclk);
      n_errors++;
      print_verdict;
   end
endmodule
